//--- include/frx_pkg.sv
package frx_pkg;

  localparam int DATA_W = 8;
  localparam int ADDR_W = 5;
  localparam int PC_W   = 11;
  localparam int LIT_W  = 9;
  localparam int NREGS  = 32;

  localparam logic [7:0] ZERO_BYTE = 8'h00;
  localparam logic [7:0] ONE_BYTE  = 8'h01;

  // Bit positions inside the status byte.
  localparam int Z_BIT   = 2;
  localparam int PAGE_LO = 5;
  localparam int PAGE_HI = 6;

  // Destination selector codes.
  localparam logic DEST_W = 1'b0;
  localparam logic DEST_F = 1'b1;

  // Values after reset.
  localparam logic [7:0]      W_RST      = 8'h00;
  localparam logic [7:0]      STATUS_RST = 8'h00;
  localparam logic [PC_W-1:0] PC_RST     = 11'h000;
  localparam logic [4:0]      ADDR_RST   = 5'h00;
  localparam logic [7:0]      RD_RST     = 8'h00;

  typedef enum logic [2:0] {
    OP_CLEAR_FILE          = 3'h0,
    OP_COMPLEMENT_FILE     = 3'h1,
    OP_DECREMENT_FILE      = 3'h2,
    OP_INCREMENT_FILE      = 3'h3,
    OP_DECREMENT_SKIP_ZERO = 3'h4,
    OP_INCREMENT_SKIP_ZERO = 3'h5,
    OP_JUMP_ABSOLUTE       = 3'h6
  } frx_op_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_EXEC = 2'b01,
    ST_NOP  = 2'b11
  } frx_state_t;

  typedef struct packed {
    frx_state_t        st;
    frx_op_t           op;
    logic [4:0]        addr;
    logic              dest;
    logic [7:0]        w;
    logic [7:0]        status;
    logic [PC_W-1:0]   pc;
  } frx_core_t;

  localparam frx_core_t CORE_RST = '{
    st:     ST_IDLE,
    op:     OP_CLEAR_FILE,
    addr:   ADDR_RST,
    dest:   DEST_W,
    w:      W_RST,
    status: STATUS_RST,
    pc:     PC_RST
  };

endpackage

//--- include/frx_rf_if.sv
`timescale 1ns/10ps
interface frx_rf_if;
  logic       rd_en;
  logic [4:0] rd_addr;
  logic [7:0] rd_data;
  logic       wr_en;
  logic [4:0] wr_addr;
  logic [7:0] wr_data;

  modport core (output rd_en, output rd_addr, input rd_data,
                output wr_en, output wr_addr, output wr_data);
  modport mem  (input rd_en, input rd_addr, output rd_data,
                input wr_en, input wr_addr, input wr_data);
endinterface

//--- rtl/frx_regfile.sv
`timescale 1ns/10ps
module frx_regfile (
  // Clock and reset
  input  wire logic clk,
  input  wire logic reset_n,
  // Core side
  frx_rf_if.mem     rf
);
  import frx_pkg::*;

  logic [7:0] mem_array [NREGS];
  logic [7:0] rd_data_ff;

  // The array itself has no reset; only the read register is cleared.
  always_ff @(posedge clk) begin
    if (rf.wr_en) begin
      mem_array[rf.wr_addr] <= rf.wr_data;
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      rd_data_ff <= RD_RST;
    end else if (rf.rd_en) begin
      rd_data_ff <= mem_array[rf.rd_addr];
    end
  end

  assign rf.rd_data = rd_data_ff;
endmodule

//--- rtl/frx_exec.sv
`timescale 1ns/10ps
module frx_exec (
  // Clock and reset
  input  wire logic                   clk,
  input  wire logic                   reset_n,
  // Instruction from the fetch stage
  input  wire logic                   instr_valid,
  output logic                        instr_ready,
  input  wire frx_pkg::frx_op_t       instr_op,
  input  wire logic [4:0]             instr_addr,
  input  wire logic                   instr_dest,
  input  wire logic [8:0]             instr_lit,
  // Loads from the rest of the core
  input  wire logic                   file_load_en,
  input  wire logic [4:0]             file_load_addr,
  input  wire logic [7:0]             file_load_data,
  input  wire logic                   status_load_en,
  input  wire logic [7:0]             status_load_data,
  // Architectural state
  output logic [7:0]                  w_out,
  output logic [7:0]                  status_out,
  output logic [frx_pkg::PC_W-1:0]    pc_out,
  // Pipeline control
  output logic                        skip_next
);
  import frx_pkg::*;

  frx_core_t  state_ff;
  frx_core_t  nxt_state;
  logic [7:0] result;
  logic       accept;

  frx_rf_if rf ();

  frx_regfile u_regfile (
    .clk     (clk),
    .reset_n (reset_n),
    .rf      (rf)
  );

  function automatic logic frx_is_zero(input logic [7:0] v);
    return v == ZERO_BYTE;
  endfunction

  function automatic logic [7:0] frx_alu(input frx_op_t op, input logic [7:0] f);
    logic [7:0] r;
    r = ZERO_BYTE;
    unique case (op)
      OP_CLEAR_FILE:          r = ZERO_BYTE;
      OP_COMPLEMENT_FILE:     r = ~f;
      OP_DECREMENT_FILE,
      OP_DECREMENT_SKIP_ZERO: r = f - ONE_BYTE;
      OP_INCREMENT_FILE,
      OP_INCREMENT_SKIP_ZERO: r = f + ONE_BYTE;
      OP_JUMP_ABSOLUTE:       r = ZERO_BYTE;
    endcase
    return r;
  endfunction

  function automatic logic frx_sets_zero(input frx_op_t op);
    return op inside {OP_CLEAR_FILE, OP_COMPLEMENT_FILE,
                      OP_DECREMENT_FILE, OP_INCREMENT_FILE};
  endfunction

  function automatic logic frx_is_skip(input frx_op_t op);
    return op inside {OP_DECREMENT_SKIP_ZERO, OP_INCREMENT_SKIP_ZERO};
  endfunction

  assign accept = instr_valid && (state_ff.st == ST_IDLE);

  always_comb begin
    nxt_state   = state_ff;
    result      = ZERO_BYTE;
    skip_next   = 1'b0;
    rf.rd_en    = 1'b0;
    rf.rd_addr  = instr_addr;
    rf.wr_en    = 1'b0;
    rf.wr_addr  = state_ff.addr;
    rf.wr_data  = ZERO_BYTE;
    // Outside execution the rest of the core may rewrite the status byte.
    if (status_load_en && state_ff.st != ST_EXEC) begin
      nxt_state.status = status_load_data;
    end
    unique case (state_ff.st)
      ST_IDLE: begin
        if (instr_valid) begin
          nxt_state.op   = instr_op;
          nxt_state.addr = instr_addr;
          nxt_state.dest = instr_dest;
          if (instr_op == OP_JUMP_ABSOLUTE) begin
            nxt_state.pc = {state_ff.status[PAGE_HI:PAGE_LO], instr_lit};
            nxt_state.st = ST_NOP;
          end else begin
            rf.rd_en     = 1'b1;
            nxt_state.pc = state_ff.pc + 11'h001;
            nxt_state.st = ST_EXEC;
          end
        end
      end
      ST_EXEC: begin
        result = frx_alu(state_ff.op, rf.rd_data);
        if (frx_sets_zero(state_ff.op)) begin
          nxt_state.status[Z_BIT] = frx_is_zero(result);
        end
        // Clearing has no destination bit and always lands in the file.
        if (state_ff.op == OP_CLEAR_FILE || state_ff.dest == DEST_F) begin
          rf.wr_en   = 1'b1;
          rf.wr_data = result;
        end else begin
          nxt_state.w = result;
        end
        if (frx_is_skip(state_ff.op) && frx_is_zero(result)) begin
          skip_next    = 1'b1;
          nxt_state.pc = state_ff.pc + 11'h001;
          nxt_state.st = ST_NOP;
        end else begin
          nxt_state.st = ST_IDLE;
        end
      end
      ST_NOP: begin
        nxt_state.st = ST_IDLE;
      end
      default: begin
        nxt_state.st = ST_IDLE;
      end
    endcase
    // Execution write-back has priority; a core load in that cycle is dropped.
    if (file_load_en && state_ff.st != ST_EXEC) begin
      rf.wr_en   = 1'b1;
      rf.wr_addr = file_load_addr;
      rf.wr_data = file_load_data;
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      state_ff <= CORE_RST;
    end else begin
      state_ff <= nxt_state;
    end
  end

  assign instr_ready = (state_ff.st == ST_IDLE);
  assign w_out       = state_ff.w;
  assign status_out  = state_ff.status;
  assign pc_out      = state_ff.pc;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!reset_n);

  a_clear_writes_zero: assert property (
    (accept && instr_op == OP_CLEAR_FILE)
      |-> ##1 (rf.wr_en && rf.wr_data == ZERO_BYTE) ##1 status_out[Z_BIT])
    else $error("clear did not write zero and set the zero flag");

  a_complement_to_w: assert property (
    (accept && instr_op == OP_COMPLEMENT_FILE && instr_dest == DEST_W)
      |-> ##2 (w_out == ~$past(rf.rd_data)))
    else $error("complement result missing from working register");

  a_decrement_to_f: assert property (
    (state_ff.st == ST_EXEC && state_ff.op == OP_DECREMENT_FILE && state_ff.dest == DEST_F)
      |-> (rf.wr_en && rf.wr_addr == state_ff.addr && rf.wr_data == rf.rd_data - ONE_BYTE))
    else $error("decrement write-back wrong");

  a_zero_flag_follows: assert property (
    (state_ff.st == ST_EXEC && frx_sets_zero(state_ff.op))
      |=> (status_out[Z_BIT] == frx_is_zero($past(result))))
    else $error("zero flag does not follow the result");

  a_skip_keeps_status: assert property (
    (state_ff.st == ST_EXEC && frx_is_skip(state_ff.op)) |=> $stable(status_out))
    else $error("skip instruction changed the status byte");

  a_skip_on_zero: assert property (
    (accept && instr_op == OP_INCREMENT_SKIP_ZERO && instr_dest == DEST_W)
      ##1 (rf.rd_data == 8'hff)
      |-> skip_next ##1 (!instr_ready && w_out == ZERO_BYTE) ##1 instr_ready)
    else $error("zero result did not discard the next slot");

  a_no_skip_nonzero: assert property (
    (state_ff.st == ST_EXEC && !frx_is_zero(result)) |-> (!skip_next ##1 instr_ready))
    else $error("skip taken on a nonzero result");

  a_dest_w_no_write: assert property (
    (state_ff.st == ST_EXEC && state_ff.dest == DEST_W && state_ff.op != OP_CLEAR_FILE)
      |-> !rf.wr_en ##1 (w_out == $past(result)))
    else $error("working register destination wrote the file");

  a_jump_loads_pc: assert property (
    (accept && instr_op == OP_JUMP_ABSOLUTE)
      |=> (pc_out == {$past(status_out[PAGE_HI:PAGE_LO]), $past(instr_lit)} && !instr_ready)
      ##1 instr_ready)
    else $error("jump target or length wrong");

  a_busy_after_accept: assert property (
    accept
      |=> !instr_ready)
    else $error("core still ready after taking an instruction");

  a_read_on_accept: assert property (
    (accept && instr_op != OP_JUMP_ABSOLUTE)
      |-> (rf.rd_en && rf.rd_addr == instr_addr))
    else $error("file operand not read from the offered address");

  a_pc_step_file: assert property (
    (accept && instr_op != OP_JUMP_ABSOLUTE)
      |=> (pc_out == $past(pc_out) + 11'h001))
    else $error("program counter did not step on a file operation");

  a_skip_pc_step: assert property (
    skip_next
      |=> (pc_out == $past(pc_out) + 11'h001))
    else $error("skipped slot did not advance the program counter");

  a_skip_op_only: assert property (
    skip_next
      |-> (state_ff.st == ST_EXEC && frx_is_skip(state_ff.op)))
    else $error("skip requested outside a skip instruction");

  a_skip_wait_slot: assert property (
    skip_next
      |=> (!instr_ready ##1 instr_ready))
    else $error("skip did not insert exactly one empty slot");

  a_nop_slot_quiet: assert property (
    (state_ff.st == ST_NOP)
      |-> (!skip_next && !rf.rd_en))
    else $error("empty slot did work");

  a_dec_skip_one: assert property (
    (state_ff.st == ST_EXEC && state_ff.op == OP_DECREMENT_SKIP_ZERO && rf.rd_data == ONE_BYTE)
      |-> skip_next)
    else $error("decrement to zero did not skip");

  a_inc_skip_writeback: assert property (
    (state_ff.st == ST_EXEC && state_ff.op == OP_INCREMENT_SKIP_ZERO && state_ff.dest == DEST_F)
      |-> (rf.wr_en && rf.wr_data == rf.rd_data + ONE_BYTE))
    else $error("increment-and-skip write-back wrong");

  a_dec_skip_w: assert property (
    (state_ff.st == ST_EXEC && state_ff.op == OP_DECREMENT_SKIP_ZERO && state_ff.dest == DEST_W)
      |=> (w_out == $past(rf.rd_data) - ONE_BYTE))
    else $error("decrement-and-skip result missing from working register");

  a_complement_to_f: assert property (
    (state_ff.st == ST_EXEC && state_ff.op == OP_COMPLEMENT_FILE && state_ff.dest == DEST_F)
      |-> (rf.wr_en && rf.wr_data == ~rf.rd_data))
    else $error("complement write-back wrong");

  a_increment_to_w: assert property (
    (state_ff.st == ST_EXEC && state_ff.op == OP_INCREMENT_FILE && state_ff.dest == DEST_W)
      |=> (w_out == $past(rf.rd_data) + ONE_BYTE))
    else $error("increment result missing from working register");

  a_decrement_flag: assert property (
    (state_ff.st == ST_EXEC && state_ff.op == OP_DECREMENT_FILE)
      |=> (status_out[Z_BIT] == ($past(rf.rd_data) == ONE_BYTE)))
    else $error("decrement zero flag wrong");

  a_increment_flag: assert property (
    (state_ff.st == ST_EXEC && state_ff.op == OP_INCREMENT_FILE)
      |=> (status_out[Z_BIT] == ($past(rf.rd_data) == 8'hff)))
    else $error("increment zero flag wrong");

  a_complement_flag: assert property (
    (state_ff.st == ST_EXEC && state_ff.op == OP_COMPLEMENT_FILE)
      |=> (status_out[Z_BIT] == ($past(rf.rd_data) == 8'hff)))
    else $error("complement zero flag wrong");

  a_clear_keeps_w: assert property (
    (state_ff.st == ST_EXEC && state_ff.op == OP_CLEAR_FILE)
      |=> $stable(w_out))
    else $error("clear disturbed the working register");

  a_dest_keeps_w: assert property (
    (state_ff.st == ST_EXEC && state_ff.dest == DEST_F)
      |=> $stable(w_out))
    else $error("file destination disturbed the working register");

  a_write_to_addressed: assert property (
    (state_ff.st == ST_EXEC && rf.wr_en)
      |-> (rf.wr_addr == state_ff.addr))
    else $error("write-back went to the wrong file register");

  a_jump_keeps_regs: assert property (
    (accept && instr_op == OP_JUMP_ABSOLUTE && !status_load_en)
      |=> ($stable(status_out) && $stable(w_out)))
    else $error("jump changed status or working register");

  a_page_bits_kept: assert property (
    (state_ff.st == ST_EXEC && frx_sets_zero(state_ff.op))
      |=> (status_out[PAGE_HI:PAGE_LO] == $past(status_out[PAGE_HI:PAGE_LO])))
    else $error("file operation changed the page bits");

endmodule

//--- sim/frx_fetch_model.sv
`timescale 1ns/10ps
module frx_fetch_model (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        reset_n,
  // Bench side
  input  wire logic        req,
  input  wire logic [17:0] word,
  output logic             taken,
  // Core side
  input  wire logic        instr_ready,
  output logic             instr_valid,
  output frx_pkg::frx_op_t instr_op,
  output logic [4:0]       instr_addr,
  output logic             instr_dest,
  output logic [8:0]       instr_lit
);
  import frx_pkg::*;
  logic [17:0] hold = 18'h0;
  logic        pend = 1'b0;
  logic        acc  = 1'b0;
  logic [17:0] shown;

  // Idle fields show the inverse of the last word, so stale operands never look fresh.
  assign shown       = pend ? hold : ~hold;
  assign instr_valid = pend;
  assign instr_op    = frx_op_t'(shown[17:15]);
  assign instr_addr  = shown[14:10];
  assign instr_dest  = shown[9];
  assign instr_lit   = shown[8:0];

  always @(posedge clk) begin
    acc <= pend && instr_ready;
  end

  always @(negedge clk) begin
    taken <= 1'b0;
    if (!reset_n) begin
      pend <= 1'b0;
    end else if (pend && acc) begin
      pend  <= 1'b0;
      taken <= 1'b1;
    end else if (!pend && req) begin
      pend <= 1'b1;
      hold <= word;
    end
  end
endmodule

//--- sim/frx_exec_tb.sv
`timescale 1ns/10ps
module frx_exec_tb;
  import frx_pkg::*;
  logic            clk = 1'b0;
  logic            reset_n = 1'b0;
  logic            req = 1'b0;
  logic [17:0]     word = 18'h0;
  logic            file_load_en = 1'b0;
  logic [4:0]      file_load_addr = 5'h00;
  logic [7:0]      file_load_data = 8'h00;
  logic            status_load_en = 1'b0;
  logic [7:0]      status_load_data = 8'h00;
  logic            taken, instr_valid, instr_ready, instr_dest, skip_next;
  frx_op_t         instr_op;
  logic [4:0]      instr_addr;
  logic [8:0]      instr_lit;
  logic [7:0]      w_out, status_out, w_e, st_e;
  logic [PC_W-1:0] pc_out, pc_e;
  logic [7:0]      fr [NREGS];
  int              error_cnt = 0;
  int              samples_checked = 0;
  int              cycles = 0;
  int              skips = 0;

  frx_exec frx_exec_inst (.clk, .reset_n, .instr_valid, .instr_ready, .instr_op, .instr_addr,
    .instr_dest, .instr_lit, .file_load_en, .file_load_addr, .file_load_data, .status_load_en,
    .status_load_data, .w_out, .status_out, .pc_out, .skip_next);
  frx_fetch_model frx_fetch_model_inst (.clk, .reset_n, .req, .word, .taken, .instr_ready,
    .instr_valid, .instr_op, .instr_addr, .instr_dest, .instr_lit);

  always #5 clk = ~clk;

  // The whole run needs about 2000 cycles; the ceiling leaves ample margin.
  always @(posedge clk) begin
    cycles++;
    if (skip_next === 1'b1) begin
      skips++;
    end
    if (cycles == 20000) begin
      error_cnt++;
      conclude();
    end
  end

  task automatic conclude();
    $display("checks %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("mismatch t=%0t seen %h exp %h", $time, seen, exp);
    end
  endtask

  function automatic logic [7:0] calc(input frx_op_t op, input logic [7:0] f);
    case (op)
      OP_CLEAR_FILE: return 8'h00;
      OP_COMPLEMENT_FILE: return ~f;
      OP_DECREMENT_FILE, OP_DECREMENT_SKIP_ZERO: return f - 8'h01;
      default: return f + 8'h01;
    endcase
  endfunction

  function automatic logic [7:0] pick();
    case ($urandom % 4)
      0: return 8'h00;
      1: return 8'h01;
      2: return 8'hff;
      default: return 8'($urandom);
    endcase
  endfunction

  // Loads are only made while the core is idle, since loads in its execution slot are dropped.
  task automatic load(input logic st, input logic [4:0] a, input logic [7:0] d);
    @(negedge clk);
    file_load_en     = !st;
    status_load_en   = st;
    file_load_addr   = a;
    file_load_data   = d;
    status_load_data = d;
    if (st) begin
      st_e = d;
    end else begin
      fr[a] = d;
    end
    @(negedge clk);
    file_load_en   = 1'b0;
    status_load_en = 1'b0;
  endtask

  task automatic run(input frx_op_t op, input logic [4:0] a, input logic d, input logic [8:0] k);
    logic [7:0] r;
    logic       z;
    int         n;
    int         s0;
    s0 = skips;
    r  = calc(op, fr[a]);
    z  = (op inside {OP_DECREMENT_SKIP_ZERO, OP_INCREMENT_SKIP_ZERO}) && r == 8'h00;
    if (op == OP_JUMP_ABSOLUTE) begin
      pc_e = {st_e[PAGE_HI:PAGE_LO], k};
    end else begin
      pc_e = pc_e + (z ? 11'h002 : 11'h001);
      if (op <= OP_INCREMENT_FILE) begin
        st_e[Z_BIT] = (r == 8'h00);
      end
      if (d == DEST_F || op == OP_CLEAR_FILE) begin
        fr[a] = r;
      end else begin
        w_e = r;
      end
    end
    @(negedge clk);
    req  <= 1'b1;
    word <= {op, a, d, k};
    @(negedge clk);
    req <= 1'b0;
    repeat (20) if (taken !== 1'b1) @(negedge clk);
    n = 0;
    repeat (20) if (instr_ready !== 1'b1) begin
      @(negedge clk);
      n++;
    end
    chk(16'(n), {15'h0, z});
    chk(16'(skips - s0), {15'h0, z});
    chk(w_out, w_e);
    chk(status_out, st_e);
    chk(pc_out, pc_e);
  endtask

  initial begin
    void'($urandom(83));
    w_e  = W_RST;
    st_e = STATUS_RST;
    pc_e = PC_RST;
    repeat (12) @(negedge clk);
    reset_n = 1'b1;
    chk(instr_ready, 1'b1);
    chk(w_out, w_e);
    chk(status_out, st_e);
    chk(pc_out, pc_e);
    for (int i = 0; i < NREGS; i++) begin
      load(1'b0, 5'(i), 8'($urandom));
    end
    load(1'b0, 5'h1f, 8'hff);
    run(OP_INCREMENT_SKIP_ZERO, 5'h1f, DEST_F, 9'h000);
    load(1'b0, 5'h00, 8'h01);
    run(OP_DECREMENT_SKIP_ZERO, 5'h00, DEST_W, 9'h000);
    load(1'b1, 5'h00, 8'h64);
    run(OP_JUMP_ABSOLUTE, 5'h00, DEST_W, 9'h1ff);
    run(OP_CLEAR_FILE, 5'h1f, DEST_W, 9'h000);
    run(OP_COMPLEMENT_FILE, 5'h1f, DEST_W, 9'h000);
    load(1'b0, 5'h03, 8'hff);
    run(OP_INCREMENT_SKIP_ZERO, 5'h03, DEST_W, 9'h000);
    for (int o = 0; o < 7; o++) begin
      run(frx_op_t'(o), 5'(o), DEST_F, 9'(o));
    end
    repeat (400) begin
      if ($urandom % 4 == 0) begin
        load(1'($urandom % 3 == 0), 5'($urandom), pick());
      end
      run(frx_op_t'($urandom % 7), 5'($urandom), 1'($urandom), 9'($urandom));
    end
    conclude();
  end
endmodule
